// [verilog/gpl_params.svh]
`ifndef GPL_PARAMS_SVH
`define GPL_PARAMS_SVH

// Register byte offsets
`define GPL_ADDR_CTRL    4'h0
`define GPL_ADDR_DELAY   4'h4
`define GPL_ADDR_DIV     4'h8
`define GPL_ADDR_STAT    4'hC

// Control register fields
`define GPL_F_MODE       2:0
`define GPL_F_IN_REG     3
`define GPL_F_IN_FALL    4
`define GPL_F_OUT_REG    5
`define GPL_F_OUT_FALL   6
`define GPL_F_OUT_INV    7
`define GPL_F_DDR        9:8
`define GPL_F_SERDES     10
`define GPL_F_PULL_DOWN  11

// Delay register fields
`define GPL_F_SE_IN      3:0
`define GPL_F_SE_OUT     7:4
`define GPL_F_DIFF_RX    13:8
`define GPL_F_DIFF_TX    21:16
`define GPL_F_DYN_EN     24
`define GPL_F_DIFF       25

// Divider register fields (half period minus one, in sys_clk cycles)
`define GPL_F_IN_DIV     7:0
`define GPL_F_OUT_DIV    15:8

// Pin modes
`define GPL_MODE_UNUSED  3'h0
`define GPL_MODE_INPUT   3'h1
`define GPL_MODE_OUTPUT  3'h2
`define GPL_MODE_BIDIR   3'h3
`define GPL_MODE_CLKOUT  3'h4

// Double-data variants
`define GPL_DDR_OFF      2'h0
`define GPL_DDR_NORMAL   2'h1
`define GPL_DDR_RESYNC   2'h2
`define GPL_DDR_PIPE     2'h3

// Reset values
`define GPL_CTRL_RST     32'h0000_0000
`define GPL_DELAY_RST    32'h0000_0000
`define GPL_DIV_RST      32'h0000_0101

// Delay chain step sizes in ps, applied by the analog chain
`define GPL_SE_STEP_PS   60
`define GPL_DIFF_STEP_PS 25
`define GPL_DYN_MAX      6'h3F

// Bus answers
`define GPL_RESP_OKAY    2'h0
`define GPL_RESP_SLVERR  2'h2

`endif

// [verilog/gpl_pkg.sv]
package gpl_pkg;

  typedef struct packed {
    logic [3:0] data;
    logic       oe;
  } gpl_core_tx_t;

  typedef struct packed {
    logic [3:0] data;
  } gpl_core_rx_t;

endpackage

// [verilog/gpl_top.sv]
`include "gpl_params.svh"

// Notes on behaviour
// - Input mode enables receive only, optional register on chosen input-clock edge.
// - Alternate input route never passes the input register.
// - Double-data input samples pad on both input-clock edges into two streams.
// - Output mode enables transmit only, optional register on chosen output-clock edge.
// - Registered output data may be inverted in output and bidirectional modes.
// - Double-data output captures two bits on opposite edges, muxed onto pad.
// - Bidirectional enables all paths; output clock registers data and enable.
// - Input and output registering are chosen independently in bidirectional mode.
// - Clock-output mode forwards the output clock to the pad.
// - While configuring, the pin is held with a weak pull-up.
// - Unused pins are tristated with weak pull-up, or selectable pull-down.
// - Double-data uses a two-bit core word per direction.
// - Normal double-data exchanges bits on both edges without retiming.
// - Resync and pipeline modes retime both bits to the rising edge.
// - Resync input delays the falling sample half a period to align.
// - One-to-four serdes only on the fast pin pair, full rate.
// - Single-ended static delay has 16 steps on input and output.
// - Differential receive static delay has 64 steps on positive input.
// - Differential transmit static delay offers 64 settings.
// - Dynamic delay acts on receive only, 64 steps, fast pair only.
// - Deserialised first bit lands on bit zero, last on bit three.
// - Bit zero is the rising sample, bit one the falling sample.
module gpl_top
  import gpl_pkg::*;
#(
  parameter bit FAST_PAIR = 1'b1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         config_active,
  input  wire gpl_core_tx_t core_tx,
  output gpl_core_rx_t      core_rx,
  input  wire logic         delay_adjust_enable,
  input  wire logic         delay_adjust_direction,
  output logic              alt_route,
  input  wire logic         pad_in,
  output logic              pad_out,
  output logic              pad_oe,
  output logic              pad_pull_up,
  output logic              pad_pull_down,
  output logic [5:0]        rx_static_tap,
  output logic [5:0]        rx_dynamic_tap,
  output logic [5:0]        tx_static_tap
);

  function automatic logic [31:0] gpl_strb_mask(input logic [3:0] strb);
    gpl_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  logic [31:0] ctrl_r;
  logic [31:0] delay_r;
  logic [31:0] div_r;

  // Register bus state
  logic        aw_held_r;
  logic        w_held_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Pin synchronisers
  logic pad_meta_r;
  logic pad_sync_r;
  logic cfg_meta_r;
  logic cfg_sync_r;

  // Clock dividers for the input and output clocks
  logic [7:0] in_cnt_r;
  logic       in_ph_r;
  logic [7:0] out_cnt_r;
  logic       out_ph_r;

  // Data path state
  logic       rx_fall_hold_r;
  logic       rx_rise_hold_r;
  logic [3:0] rx_shift_r;
  logic [1:0] rx_cnt_r;
  logic [2:0] tx_shift_r;
  logic [1:0] tx_cnt_r;
  logic       tx_fall_hold_r;
  logic [1:0] tx_pipe_r;
  logic [5:0] dyn_tap_r;

  // Decoded configuration
  wire [2:0] mode       = ctrl_r[`GPL_F_MODE];
  wire [1:0] ddr        = ctrl_r[`GPL_F_DDR];
  wire       rx_en      = (mode == `GPL_MODE_INPUT) || (mode == `GPL_MODE_BIDIR);
  wire       tx_en      = (mode == `GPL_MODE_OUTPUT) || (mode == `GPL_MODE_BIDIR);
  wire       serdes_on  = ctrl_r[`GPL_F_SERDES] && FAST_PAIR && (ddr == `GPL_DDR_OFF);
  wire       out_regd   = ctrl_r[`GPL_F_OUT_REG] || (ddr != `GPL_DDR_OFF) || serdes_on;
  wire       inv        = ctrl_r[`GPL_F_OUT_INV] && out_regd;
  wire       diff       = delay_r[`GPL_F_DIFF];
  wire       dyn_on     = delay_r[`GPL_F_DYN_EN] && FAST_PAIR;

  wire       in_wrap    = (in_cnt_r == div_r[`GPL_F_IN_DIV]);
  wire       in_rise    = in_wrap && !in_ph_r;
  wire       in_fall    = in_wrap && in_ph_r;
  wire       in_edge    = ctrl_r[`GPL_F_IN_FALL] ? in_fall : in_rise;
  wire       out_wrap   = (out_cnt_r == div_r[`GPL_F_OUT_DIV]);
  wire       out_rise   = out_wrap && !out_ph_r;
  wire       out_fall   = out_wrap && out_ph_r;
  wire       out_edge   = ctrl_r[`GPL_F_OUT_FALL] ? out_fall : out_rise;

  // Bus decode
  wire        wr_go     = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [3:0]  wr_addr   = {awaddr_r[3:2], 2'h0};
  wire [3:0]  rd_addr   = {s_axi_araddr[3:2], 2'h0};
  wire [31:0] wr_mask   = gpl_strb_mask(wstrb_r);
  wire        wr_hit    = (wr_addr != `GPL_ADDR_STAT);
  wire [31:0] stat_word = {18'h0, cfg_sync_r, pad_sync_r, core_rx.data, 2'h0, dyn_tap_r};
  wire [31:0] rd_word   = (rd_addr == `GPL_ADDR_CTRL)  ? ctrl_r  :
                          (rd_addr == `GPL_ADDR_DELAY) ? delay_r :
                          (rd_addr == `GPL_ADDR_DIV)   ? div_r   : stat_word;

  // Write channel: address and data taken in either order, answer after both
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `GPL_RESP_OKAY : `GPL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= `GPL_CTRL_RST;
      delay_r <= `GPL_DELAY_RST;
      div_r   <= `GPL_DIV_RST;
    end else if (wr_go) begin
      if (wr_addr == `GPL_ADDR_CTRL) begin
        ctrl_r <= (ctrl_r & ~wr_mask) | (wdata_r & wr_mask);
      end
      if (wr_addr == `GPL_ADDR_DELAY) begin
        delay_r <= (delay_r & ~wr_mask) | (wdata_r & wr_mask);
      end
      if (wr_addr == `GPL_ADDR_DIV) begin
        div_r <= (div_r & ~wr_mask) | (wdata_r & wr_mask);
      end
    end
  end

  // Read channel: one cycle to answer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `GPL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= `GPL_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pad and configuration level arrive from outside the clock domain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_meta_r <= 1'b0;
      pad_sync_r <= 1'b0;
      cfg_meta_r <= 1'b1;
      cfg_sync_r <= 1'b1;
    end else begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
      cfg_meta_r <= config_active;
      cfg_sync_r <= cfg_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alt_route <= 1'b0;
    end else begin
      alt_route <= pad_sync_r;
    end
  end

  // Input and output clocks are enable pulses, not real clocks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_cnt_r  <= 8'h00;
      in_ph_r   <= 1'b0;
      out_cnt_r <= 8'h00;
      out_ph_r  <= 1'b0;
    end else begin
      in_cnt_r  <= in_wrap ? 8'h00 : in_cnt_r + 8'h01;
      in_ph_r   <= in_ph_r ^ in_wrap;
      out_cnt_r <= out_wrap ? 8'h00 : out_cnt_r + 8'h01;
      out_ph_r  <= out_ph_r ^ out_wrap;
    end
  end

  // Receive path; runs whenever the mode has it, whatever the enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_rx        <= '0;
      rx_fall_hold_r <= 1'b0;
      rx_rise_hold_r <= 1'b0;
      rx_shift_r     <= 4'h0;
      rx_cnt_r       <= 2'h0;
    end else if (rx_en) begin
      if (serdes_on) begin
        if (in_edge) begin
          rx_shift_r <= {pad_sync_r, rx_shift_r[3:1]};
          rx_cnt_r   <= rx_cnt_r + 2'h1;
          if (rx_cnt_r == 2'h3) begin
            core_rx.data <= {pad_sync_r, rx_shift_r[3:1]};
          end
        end
      end else begin
        case (ddr)
          `GPL_DDR_NORMAL: begin
            if (in_rise) begin
              core_rx.data[0] <= pad_sync_r;
            end
            if (in_fall) begin
              core_rx.data[1] <= pad_sync_r;
            end
          end
          `GPL_DDR_RESYNC: begin
            if (in_fall) begin
              rx_fall_hold_r <= pad_sync_r;
            end
            if (in_rise) begin
              core_rx.data[1:0] <= {rx_fall_hold_r, pad_sync_r};
            end
          end
          `GPL_DDR_PIPE: begin
            if (in_fall) begin
              rx_fall_hold_r <= pad_sync_r;
            end
            if (in_rise) begin
              rx_rise_hold_r    <= pad_sync_r;
              core_rx.data[1:0] <= {rx_fall_hold_r, rx_rise_hold_r};
            end
          end
          default: begin
            if (in_edge || !ctrl_r[`GPL_F_IN_REG]) begin
              core_rx.data[0] <= pad_sync_r;
            end
          end
        endcase
      end
    end
  end

  // Transmit path and pad driver
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_out        <= 1'b0;
      pad_oe         <= 1'b0;
      tx_shift_r     <= 3'h0;
      tx_cnt_r       <= 2'h0;
      tx_fall_hold_r <= 1'b0;
      tx_pipe_r      <= 2'h0;
    end else if (cfg_sync_r || !(tx_en || mode == `GPL_MODE_CLKOUT)) begin
      pad_oe <= 1'b0;
    end else if (mode == `GPL_MODE_CLKOUT) begin
      pad_oe  <= 1'b1;
      pad_out <= out_ph_r;
    end else begin
      if (mode == `GPL_MODE_OUTPUT) begin
        pad_oe <= 1'b1;
      end else if (!out_regd || out_edge) begin
        pad_oe <= core_tx.oe;
      end
      if (serdes_on) begin
        if (out_edge) begin
          tx_cnt_r <= tx_cnt_r + 2'h1;
          if (tx_cnt_r == 2'h0) begin
            pad_out    <= core_tx.data[0] ^ inv;
            tx_shift_r <= core_tx.data[3:1];
          end else begin
            pad_out    <= tx_shift_r[0] ^ inv;
            tx_shift_r <= {1'b0, tx_shift_r[2:1]};
          end
        end
      end else begin
        case (ddr)
          `GPL_DDR_NORMAL: begin
            if (out_rise) begin
              pad_out <= core_tx.data[0] ^ inv;
            end
            if (out_fall) begin
              pad_out <= core_tx.data[1] ^ inv;
            end
          end
          `GPL_DDR_RESYNC: begin
            if (out_rise) begin
              pad_out        <= core_tx.data[0] ^ inv;
              tx_fall_hold_r <= core_tx.data[1];
            end
            if (out_fall) begin
              pad_out <= tx_fall_hold_r ^ inv;
            end
          end
          `GPL_DDR_PIPE: begin
            if (out_rise) begin
              tx_pipe_r      <= core_tx.data[1:0];
              pad_out        <= tx_pipe_r[0] ^ inv;
              tx_fall_hold_r <= tx_pipe_r[1];
            end
            if (out_fall) begin
              pad_out <= tx_fall_hold_r ^ inv;
            end
          end
          default: begin
            if (out_edge || !out_regd) begin
              pad_out <= core_tx.data[0] ^ inv;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_pull_up   <= 1'b1;
      pad_pull_down <= 1'b0;
    end else begin
      pad_pull_up   <= cfg_sync_r ||
                       (mode == `GPL_MODE_UNUSED && !ctrl_r[`GPL_F_PULL_DOWN]);
      pad_pull_down <= !cfg_sync_r && mode == `GPL_MODE_UNUSED && ctrl_r[`GPL_F_PULL_DOWN];
    end
  end

  // Dynamic tap counter, saturating at both ends
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dyn_tap_r <= 6'h00;
    end else if (dyn_on && delay_adjust_enable) begin
      if (delay_adjust_direction && dyn_tap_r != `GPL_DYN_MAX) begin
        dyn_tap_r <= dyn_tap_r + 6'h01;
      end else if (!delay_adjust_direction && dyn_tap_r != 6'h00) begin
        dyn_tap_r <= dyn_tap_r - 6'h01;
      end
    end
  end

  // Static taps; differential receive drops static when dynamic is on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_static_tap  <= 6'h00;
      rx_dynamic_tap <= 6'h00;
      tx_static_tap  <= 6'h00;
    end else begin
      if (diff && FAST_PAIR) begin
        rx_static_tap <= dyn_on ? 6'h00 : delay_r[`GPL_F_DIFF_RX];
        tx_static_tap <= delay_r[`GPL_F_DIFF_TX];
      end else begin
        rx_static_tap <= {2'h0, delay_r[`GPL_F_SE_IN]};
        tx_static_tap <= {2'h0, delay_r[`GPL_F_SE_OUT]};
      end
      rx_dynamic_tap <= dyn_on ? dyn_tap_r : 6'h00;
    end
  end

endmodule

// [test/gpl_top_asserts.sv]
module gpl_top_asserts (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       config_active,
  input wire logic       pad_in,
  input wire logic       alt_route,
  input wire logic       pad_oe,
  input wire logic       pad_pull_up,
  input wire logic       pad_pull_down,
  input wire logic       delay_adjust_enable,
  input wire logic       delay_adjust_direction,
  input wire logic [5:0] rx_dynamic_tap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_cnt_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Past values before this are still reset debris
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) up_cnt_r <= 2'h0;
    else if (up_cnt_r != 2'h3) up_cnt_r <= up_cnt_r + 2'h1;
  end

  a_config_pull: assert property (
    config_active[*4] |-> pad_pull_up && !pad_oe) else $error("pin not parked");
  a_pull_excl: assert property (
    pad_pull_down |-> !pad_pull_up && !pad_oe) else $error("bad pull state");
  a_alt_delay: assert property (
    up_cnt_r == 2'h3 |-> alt_route == $past(pad_in, 3)) else $error("alt route late");
  a_dyn_top: assert property (
    delay_adjust_direction[*3] ##0 rx_dynamic_tap == 6'h3F |=> rx_dynamic_tap == 6'h3F)
    else $error("tap wrapped up");
  a_dyn_floor: assert property (
    (!delay_adjust_direction)[*3] ##0 rx_dynamic_tap == 6'h00 |=> rx_dynamic_tap == 6'h00)
    else $error("tap wrapped down");
  a_dyn_hold: assert property (
    (!delay_adjust_enable)[*3] |=> $stable(rx_dynamic_tap)) else $error("tap moved");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");

  c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
  c_dyn_top: cover property (rx_dynamic_tap == 6'h3F);
  c_config: cover property (config_active && pad_pull_up);
endmodule

bind gpl_top gpl_top_asserts i_gpl_top_asserts (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .config_active(config_active), .pad_in(pad_in), .alt_route(alt_route),
  .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
  .delay_adjust_enable(delay_adjust_enable),
  .delay_adjust_direction(delay_adjust_direction), .rx_dynamic_tap(rx_dynamic_tap));

// [test/gpl_pad_model.sv]
module gpl_pad_model (
  input wire logic sys_clk,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pull_up,
  input wire logic pad_pull_down,
  input wire logic drv_en,
  input wire logic drv_val,
  output logic     pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt_r;

  // Floating wire wanders, so no stale level hides a fault
  initial flt_r = 1'b0;
  always @(posedge sys_clk) flt_r <= ~flt_r;

  // pin driver wins, else device, else pulls
  always_comb begin
    if (pad_oe) pad_in = pad_out;
    else if (drv_en) pad_in = drv_val;
    else if (pad_pull_up) pad_in = 1'b1;
    else if (pad_pull_down) pad_in = 1'b0;
    else pad_in = flt_r;
  end
endmodule

// [test/tb_gpl_top.sv]
module tb_gpl_top;
  import gpl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         sys_clk, reset_n, config_active, drv_en, drv_val, pad_in, prev;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd_d;
  logic         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic         delay_adjust_enable, delay_adjust_direction, alt_route;
  logic         pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [5:0]   rx_static_tap, rx_dynamic_tap, tx_static_tap;
  gpl_core_tx_t core_tx;
  gpl_core_rx_t core_rx;
  int           error_cnt, n_checks, cnt;
  logic [31:0]  ctl [6] = '{32'h9, 32'h19, 32'h103, 32'h203, 32'h303, 32'h403};
  logic [3:0]   msk [6] = '{4'h1, 4'h1, 4'h3, 4'h3, 4'h3, 4'hF};

  gpl_top i_gpl_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .config_active(config_active), .core_tx(core_tx), .core_rx(core_rx),
    .delay_adjust_enable(delay_adjust_enable),
    .delay_adjust_direction(delay_adjust_direction), .alt_route(alt_route),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .rx_static_tap(rx_static_tap),
    .rx_dynamic_tap(rx_dynamic_tap), .tx_static_tap(tx_static_tap));

  gpl_pad_model i_gpl_pad_model (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .drv_en(drv_en),
    .drv_val(drv_val), .pad_in(pad_in));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the edge, so valid drops only after it was seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awready && !a_ok) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Whole run is about a thousand cycles; this leaves ample margin
  initial begin
    cyc(20000);
    error_cnt++;
    finish_test;
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, drv_en, drv_val, core_tx} = '0;
    {delay_adjust_enable, delay_adjust_direction, reset_n} = '0;
    s_axi_wstrb = 4'hF;
    config_active = 1'b1;
    cyc(3);
    reset_n <= 1'b1;
    cyc(2);
    chk({pad_pull_up, pad_oe}, 2'b10);
    config_active <= 1'b0;
    cyc(4);
    rd(4'h8);
    chk(rd_d, 32'h101);
    chk(resp, 2'h0);
    chk({pad_pull_up, pad_pull_down, pad_oe}, 3'b100);
    wr(4'h0, 32'h800);
    cyc(3);
    chk({pad_pull_up, pad_pull_down, pad_oe}, 3'b010);
    wr(4'hC, 32'h0);
    chk(resp, 2'h2);
    drv_en <= 1'b1;
    core_tx.oe <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      drv_val <= i[0];
      core_tx.data <= {4{i[0]}};
      wr(4'h0, ctl[i/2]);
      cyc(48);
      chk(core_rx.data & msk[i/2], i[0] ? msk[i/2] : 4'h0);
      chk(pad_oe, i > 3);
    end
    // Distinct rise and fall bits looped through the pad expose a swapped lane
    core_tx <= {4'h1, 1'b1};
    wr(4'h0, 32'h103);
    cyc(24);
    chk(core_rx.data[1:0], 2'h1);
    core_tx <= {4'h1, 1'b0};
    wr(4'h0, 32'h2);
    cyc(4);
    chk({pad_oe, pad_out}, 2'b11);
    wr(4'h0, 32'hE2);
    cyc(12);
    chk(pad_out, 1'b0);
    config_active <= 1'b1;
    cyc(4);
    chk({pad_pull_up, pad_oe}, 2'b10);
    config_active <= 1'b0;
    drv_val <= 1'b0;
    wr(4'h0, 32'h23);
    cyc(12);
    chk({pad_oe, core_rx.data[0]}, 2'b00);
    core_tx <= {4'h1, 1'b1};
    cyc(12);
    chk({pad_oe, pad_out, core_rx.data[0]}, 3'b111);
    wr(4'h0, 32'h4);
    cyc(4);
    cnt = 0;
    prev = pad_out;
    repeat (16) begin
      cyc(1);
      if (pad_out !== prev) cnt++;
      prev = pad_out;
    end
    chk({pad_oe, cnt[7:0]}, 9'h108);
    wr(4'h4, 32'hAF);
    cyc(3);
    chk({tx_static_tap, rx_static_tap}, {6'h0A, 6'h0F});
    wr(4'h4, 32'h022A_3F00);
    cyc(3);
    chk({tx_static_tap, rx_static_tap}, {6'h2A, 6'h3F});
    wr(4'h4, 32'h0100_0000);
    delay_adjust_direction <= 1'b1;
    delay_adjust_enable <= 1'b1;
    cyc(70);
    delay_adjust_enable <= 1'b0;
    cyc(4);
    rd(4'hC);
    chk({rx_dynamic_tap, rd_d[5:0]}, {6'h3F, 6'h3F});
    delay_adjust_direction <= 1'b0;
    delay_adjust_enable <= 1'b1;
    cyc(2);
    delay_adjust_enable <= 1'b0;
    cyc(4);
    chk(rx_dynamic_tap, 6'h3D);
    delay_adjust_enable <= 1'b1;
    cyc(70);
    delay_adjust_enable <= 1'b0;
    cyc(4);
    chk(rx_dynamic_tap, 6'h00);
    finish_test;
  end
endmodule
